// *** hdl/e1_control_status_regs.sv ***
// Control and status register bank of an E1 transceiver.
// Assumes a synchronous host port on clk_sys and datapaths outside that
// act on the control outputs and report events and alarms back in.
`timescale 1ns/1ps
module e1_control_status_regs #(
    parameter int unsigned LI_RECOVER_CYCLES =
        e1_ctl_pkg::LI_RECOVER_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    // Host parallel port
    input wire e1_ctl_pkg::host_req_s host_req,
    output logic [7:0] host_rdata,
    // Status inputs from the datapaths
    input wire logic [7:0] status_one_evt,
    input wire logic [7:0] status_two_evt,
    input wire e1_ctl_pkg::rx_info_evt_s rx_info_evt,
    input wire logic [7:0] sync_status,
    input wire e1_ctl_pkg::rx_alarm_s rx_alarm,
    // Control outputs
    output logic tx_store_enable,
    output logic chan_block_function_select,
    output logic idle_reg_function_select,
    output logic tx_backplane_clock_select,
    output logic es_reset_pulse,
    output logic li_reset_pulse,
    output logic li_recovering,
    output logic local_loop,
    output logic remote_loop,
    output logic framer_loop,
    output logic rx_clock_from_tx,
    output logic tx_serial_ignore,
    output logic force_ais,
    output logic force_remote_alarm,
    output logic irq_out_one,
    output logic irq_out_two
);
    // Control and mask registers written by the host
    // The host must write all of them after power-up
    logic [7:0] common_control_one_q, common_control_one_d;
    logic [7:0] common_control_two_q, common_control_two_d;
    logic [7:0] common_control_three_q, common_control_three_d;
    logic [7:0] irq_mask_one_q, irq_mask_one_d;
    logic [7:0] irq_mask_two_q, irq_mask_two_d;
    logic [7:0] rdata_q, rdata_d;

    // Derived control flops
    // The recovery counter is wide enough for the full recovery span
    logic force_ais_q, force_ais_d;
    logic force_rem_q, force_rem_d;
    logic [e1_ctl_pkg::LI_CNT_W-1:0] li_cnt_q, li_cnt_d;
    logic li_busy_q, li_busy_d;

    // Status read values and write strobes
    logic [7:0] st_one_val, st_two_val, rx_info_val;
    logic wr_st_one, wr_st_two, wr_rx_info;
    logic irq_one, irq_two;
    logic es_fall, li_rise;
    // Any receive failure that arms the automatic alarms
    logic alarm_any;

    // Decodes a write to one address
    function automatic logic wr_hit(input e1_ctl_pkg::host_req_s r,
                                    input logic [7:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction

    // Maps a host address to its read value
    // Unmapped addresses read as a fixed value
    function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                          input logic [7:0] c1,
                                          input logic [7:0] c2,
                                          input logic [7:0] c3,
                                          input logic [7:0] m1,
                                          input logic [7:0] m2,
                                          input logic [7:0] s1,
                                          input logic [7:0] s2,
                                          input logic [7:0] ri,
                                          input logic [7:0] ss);
        unique case (a)
            e1_ctl_pkg::ADDR_CTL_ONE: rd_mux = c1;
            e1_ctl_pkg::ADDR_CTL_TWO: rd_mux = c2;
            e1_ctl_pkg::ADDR_CTL_THREE: rd_mux = c3;
            e1_ctl_pkg::ADDR_IRQ_MASK_ONE: rd_mux = m1;
            e1_ctl_pkg::ADDR_IRQ_MASK_TWO: rd_mux = m2;
            e1_ctl_pkg::ADDR_STATUS_ONE: rd_mux = s1;
            e1_ctl_pkg::ADDR_STATUS_TWO: rd_mux = s2;
            e1_ctl_pkg::ADDR_RX_INFO: rd_mux = ri;
            e1_ctl_pkg::ADDR_SYNC_STATUS: rd_mux = ss;
            default: rd_mux = e1_ctl_pkg::READ_UNMAPPED;
        endcase
    endfunction

    // Write strobes to the three latched status registers; a write to
    // the live sync status address decodes to nothing and is dropped
    assign wr_st_one = wr_hit(host_req, e1_ctl_pkg::ADDR_STATUS_ONE);
    assign wr_st_two = wr_hit(host_req, e1_ctl_pkg::ADDR_STATUS_TWO);
    assign wr_rx_info = wr_hit(host_req, e1_ctl_pkg::ADDR_RX_INFO);

    // Status register one, with its own interrupt. An event in the cycle
    // of a masked write still latches, so no event is lost to a clear.
    latched_status u_status_one (
        .clk_sys(clk_sys),
        .rst(rst),
        .evt(status_one_evt),
        .wr_stb(wr_st_one),
        .wr_mask(host_req.wdata),
        .irq_mask(irq_mask_one_q),
        .read_val(st_one_val),
        .irq(irq_one)
    );

    // Status register two, with its own interrupt
    latched_status u_status_two (
        .clk_sys(clk_sys),
        .rst(rst),
        .evt(status_two_evt),
        .wr_stb(wr_st_two),
        .wr_mask(host_req.wdata),
        .irq_mask(irq_mask_two_q),
        .read_val(st_two_val),
        .irq(irq_two)
    );

    // Receive information register; the struct order is the bit order
    // It has no interrupt pin, so its mask is tied off
    latched_status u_rx_info (
        .clk_sys(clk_sys),
        .rst(rst),
        .evt(rx_info_evt),
        .wr_stb(wr_rx_info),
        .wr_mask(host_req.wdata),
        .irq_mask(8'h00),
        .read_val(rx_info_val),
        .irq()
    );

    // Elastic store reset acts on the falling edge of its bit
    // The detectors start low like the bits, so reset gives no false edge
    bit_transition u_es_edge (
        .clk_sys(clk_sys),
        .rst(rst),
        .level(common_control_three_q[e1_ctl_pkg::B_ES_RESET]),
        .rise(),
        .fall(es_fall)
    );

    // Line interface reset acts on the rising edge of its bit
    bit_transition u_li_edge (
        .clk_sys(clk_sys),
        .rst(rst),
        .level(common_control_three_q[e1_ctl_pkg::B_LI_RESET]),
        .rise(li_rise),
        .fall()
    );

    // Host writes to control and mask registers; reads pick a value.
    // A read in the cycle of a write returns the value before the write.
    always_comb begin
        common_control_one_d = common_control_one_q;
        common_control_two_d = common_control_two_q;
        common_control_three_d = common_control_three_q;
        irq_mask_one_d = irq_mask_one_q;
        irq_mask_two_d = irq_mask_two_q;
        rdata_d = rdata_q;
        if (wr_hit(host_req, e1_ctl_pkg::ADDR_CTL_ONE)) begin
            common_control_one_d = host_req.wdata;
        end
        if (wr_hit(host_req, e1_ctl_pkg::ADDR_CTL_TWO)) begin
            common_control_two_d = host_req.wdata;
        end
        if (wr_hit(host_req, e1_ctl_pkg::ADDR_CTL_THREE)) begin
            // Unassigned bits 2 and 0 always read back as zero
            common_control_three_d =
                host_req.wdata & e1_ctl_pkg::CTL_THREE_MASK;
        end
        if (wr_hit(host_req, e1_ctl_pkg::ADDR_IRQ_MASK_ONE)) begin
            irq_mask_one_d = host_req.wdata;
        end
        if (wr_hit(host_req, e1_ctl_pkg::ADDR_IRQ_MASK_TWO)) begin
            irq_mask_two_d = host_req.wdata;
        end
        if (host_req.rd) begin
            rdata_d = rd_mux(host_req.addr, common_control_one_q,
                             common_control_two_q, common_control_three_q,
                             irq_mask_one_q, irq_mask_two_q, st_one_val,
                             st_two_val, rx_info_val, sync_status);
        end
    end

    // Control and read data registers
    // Device contents are undefined at power-up; here all clear to zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            common_control_one_q <= e1_ctl_pkg::REG_RESET;
            common_control_two_q <= e1_ctl_pkg::REG_RESET;
            common_control_three_q <= e1_ctl_pkg::REG_RESET;
            irq_mask_one_q <= e1_ctl_pkg::REG_RESET;
            irq_mask_two_q <= e1_ctl_pkg::REG_RESET;
            rdata_q <= e1_ctl_pkg::REG_RESET;
        end else begin
            common_control_one_q <= common_control_one_d;
            common_control_two_q <= common_control_two_d;
            common_control_three_q <= common_control_three_d;
            irq_mask_one_q <= irq_mask_one_d;
            irq_mask_two_q <= irq_mask_two_d;
            rdata_q <= rdata_d;
        end
    end

    // Any one of the three receive failures is enough
    assign alarm_any = |rx_alarm;

    // Automatic alarms and line interface recovery timer. Both enables
    // at once is illegal for the host; both forces would then assert.
    // A new rising line reset during recovery restarts the count.
    always_comb begin
        force_ais_d = common_control_two_q[e1_ctl_pkg::B_AUTO_AIS] &&
                      alarm_any;
        force_rem_d = common_control_two_q[e1_ctl_pkg::B_AUTO_REMOTE] &&
                      alarm_any;
        li_cnt_d = li_cnt_q;
        li_busy_d = li_busy_q;
        if (li_rise) begin
            li_cnt_d = LI_RECOVER_CYCLES[e1_ctl_pkg::LI_CNT_W-1:0];
            li_busy_d = 1'b1;
        end else if (li_busy_q) begin
            li_cnt_d = li_cnt_q - 1'b1;
            // Busy drops with the last counted cycle
            li_busy_d = (li_cnt_q > 1);
        end
    end

    // Alarm and timer registers
    // Alarms are registered so the force outputs come from flops
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            force_ais_q <= 1'b0;
            force_rem_q <= 1'b0;
            li_cnt_q <= '0;
            li_busy_q <= 1'b0;
        end else begin
            force_ais_q <= force_ais_d;
            force_rem_q <= force_rem_d;
            li_cnt_q <= li_cnt_d;
            li_busy_q <= li_busy_d;
        end
    end

    // Mode outputs come straight from control flops
    // Serial ignore and clock swap follow their loop bits directly
    assign tx_store_enable =
        common_control_three_q[e1_ctl_pkg::B_TX_STORE_EN];
    assign chan_block_function_select =
        common_control_three_q[e1_ctl_pkg::B_CHAN_BLOCK_FS];
    assign idle_reg_function_select =
        common_control_three_q[e1_ctl_pkg::B_IDLE_REG_FS];
    assign tx_backplane_clock_select =
        common_control_three_q[e1_ctl_pkg::B_TX_CLK_SEL];
    assign local_loop =
        common_control_two_q[e1_ctl_pkg::B_LOCAL_LOOP];
    assign remote_loop =
        common_control_two_q[e1_ctl_pkg::B_REMOTE_LOOP];
    assign tx_serial_ignore =
        common_control_two_q[e1_ctl_pkg::B_REMOTE_LOOP];
    assign framer_loop =
        common_control_one_q[e1_ctl_pkg::B_FRAMER_LOOP];
    assign rx_clock_from_tx =
        common_control_one_q[e1_ctl_pkg::B_FRAMER_LOOP];

    // Pulses, alarms, timer and interrupts
    // Each of these is already a flop here or in a submodule
    assign es_reset_pulse = es_fall;
    assign li_reset_pulse = li_rise;
    assign li_recovering = li_busy_q;
    assign force_ais = force_ais_q;
    assign force_remote_alarm = force_rem_q;
    assign irq_out_one = irq_one;
    assign irq_out_two = irq_two;
    assign host_rdata = rdata_q;
endmodule // e1_control_status_regs

// *** hdl/e1_ctl_pkg.sv ***
// Shared constants and carriers for the E1 control and status block.
// Assumes one 50 MHz system clock and a host parallel port on top.
package e1_ctl_pkg;

    // Clock and line interface recovery time
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned LI_RECOVER_MS = 40;
    localparam int unsigned LI_RECOVER_CYCLES =
        LI_RECOVER_MS * (CLK_HZ / 1000);
    localparam int unsigned LI_CNT_W = 22;

    // Register addresses on the parallel port
    localparam logic [7:0] ADDR_STATUS_ONE = 8'h06;
    localparam logic [7:0] ADDR_STATUS_TWO = 8'h07;
    localparam logic [7:0] ADDR_RX_INFO = 8'h08;
    localparam logic [7:0] ADDR_CTL_ONE = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK_ONE = 8'h16;
    localparam logic [7:0] ADDR_IRQ_MASK_TWO = 8'h17;
    localparam logic [7:0] ADDR_CTL_TWO = 8'h1a;
    localparam logic [7:0] ADDR_CTL_THREE = 8'h1b;
    localparam logic [7:0] ADDR_SYNC_STATUS = 8'h1e;

    // Reset value of every control register
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Field positions, control register one
    localparam int unsigned B_FRAMER_LOOP = 7;
    // Field positions, control register two
    localparam int unsigned B_AUTO_AIS = 5;
    localparam int unsigned B_AUTO_REMOTE = 4;
    localparam int unsigned B_REMOTE_LOOP = 1;
    localparam int unsigned B_LOCAL_LOOP = 0;
    // Field positions, control register three
    localparam int unsigned B_TX_STORE_EN = 7;
    localparam int unsigned B_CHAN_BLOCK_FS = 6;
    localparam int unsigned B_IDLE_REG_FS = 5;
    localparam int unsigned B_ES_RESET = 4;
    localparam int unsigned B_LI_RESET = 3;
    localparam int unsigned B_TX_CLK_SEL = 1;
    // Unassigned bits of register three read back as zero
    localparam logic [7:0] CTL_THREE_MASK = 8'hfa;

    // Receive side alarm conditions watched for automatic alarms
    typedef struct packed {
        logic frame_loss;
        logic all_ones;
        logic signal_loss;
    } rx_alarm_s;

    // Receive information events, in bit order 7 down to 0
    typedef struct packed {
        logic tx_store_full_flag;
        logic tx_store_enable_or_empty_flag;
        logic jitter_limit_flag;
        logic rx_store_full_flag;
        logic rx_store_empty_flag;
        logic crc_resync_flag;
        logic align_resync_flag;
        logic multiframe_resync_flag;
    } rx_info_evt_s;

    // One host port access
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } host_req_s;

endpackage

// *** hdl/latched_status.sv ***
// One latched status register with write-mask read update.
// Assumes events are synchronous to clk_sys; levels or pulses both work.
`timescale 1ns/1ps
module latched_status (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] evt,
    input wire logic wr_stb,
    input wire logic [7:0] wr_mask,
    input wire logic [7:0] irq_mask,
    output logic [7:0] read_val,
    output logic irq
);
    logic [7:0] latch_q, latch_d;
    logic [7:0] hold_q, hold_d;
    logic irq_q, irq_d;

    // Latch events; a masked write copies and clears, events still win
    always_comb begin
        latch_d = latch_q | evt;
        hold_d = hold_q;
        if (wr_stb) begin
            hold_d = (hold_q & ~wr_mask) | ((latch_q | evt) & wr_mask);
            latch_d = (latch_q & ~wr_mask) | evt;
        end
        irq_d = |(latch_d & irq_mask);
    end

    // State registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            latch_q <= 8'h00;
            hold_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            latch_q <= latch_d;
            hold_q <= hold_d;
            irq_q <= irq_d;
        end
    end

    assign read_val = hold_q;
    assign irq = irq_q;
endmodule // latched_status

// *** hdl/bit_transition.sv ***
// Turns rising and falling edges of a control bit into one-cycle pulses.
// Assumes the bit is a register output in the clk_sys domain.
`timescale 1ns/1ps
module bit_transition (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic prev_q, prev_d;
    logic rise_q, rise_d;
    logic fall_q, fall_d;

    // Compare with last cycle's level
    always_comb begin
        prev_d = level;
        rise_d = level & ~prev_q;
        fall_d = ~level & prev_q;
    end

    // Pulse registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

    assign rise = rise_q;
    assign fall = fall_q;
endmodule // bit_transition

// *** verif/e1_ctl_assertions.sv ***
// Port checker for the E1 control and status register bank.
// Assumes binding to the top module, one clock, sync reset.
`timescale 1ns/1ps
module e1_ctl_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire e1_ctl_pkg::host_req_s host_req,
    input wire logic [7:0] host_rdata,
    input wire logic [7:0] sync_status,
    input wire e1_ctl_pkg::rx_alarm_s rx_alarm,
    input wire logic tx_store_enable,
    input wire logic chan_block_function_select,
    input wire logic tx_backplane_clock_select,
    input wire logic es_reset_pulse,
    input wire logic li_reset_pulse,
    input wire logic li_recovering,
    input wire logic remote_loop,
    input wire logic tx_serial_ignore,
    input wire logic force_ais
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Host writes to control three and two, and host read of sync status
    sequence s_c3;
        host_req.wr && host_req.addr == e1_ctl_pkg::ADDR_CTL_THREE;
    endsequence
    sequence s_c2;
        host_req.wr && host_req.addr == e1_ctl_pkg::ADDR_CTL_TWO;
    endsequence
    sequence s_ss;
        host_req.rd && host_req.addr == e1_ctl_pkg::ADDR_SYNC_STATUS;
    endsequence
    property p_tx_store;
        s_c3 |=> tx_store_enable == $past(host_req.wdata[7]);
    endproperty
    a_tx_store: assert property (p_tx_store) else $error("store enable");
    property p_chan_fs;
        s_c3 |=> chan_block_function_select == $past(host_req.wdata[6]);
    endproperty
    a_chan_fs: assert property (p_chan_fs) else $error("block select");
    property p_clk_sel;
        s_c3 |=> tx_backplane_clock_select == $past(host_req.wdata[1]);
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("clock select");
    property p_es_pulse;
        es_reset_pulse |-> $past(host_req.wr, 2) && !$past(host_req.wdata[4], 2)
            ##1 !es_reset_pulse;
    endproperty
    a_es_pulse: assert property (p_es_pulse) else $error("store reset");
    property p_li_pulse;
        li_reset_pulse |-> $past(host_req.wdata[3], 2)
            ##1 (li_recovering && !li_reset_pulse);
    endproperty
    a_li_pulse: assert property (p_li_pulse) else $error("line reset");
    property p_rl_ign;
        s_c2 |=> remote_loop == $past(host_req.wdata[1]) &&
            tx_serial_ignore == $past(host_req.wdata[1]);
    endproperty
    a_rl_ign: assert property (p_rl_ign) else $error("serial ignore");
    property p_ais;
        force_ais |-> $past(|rx_alarm);
    endproperty
    a_ais: assert property (p_ais) else $error("ais without cause");
    property p_sync_rd;
        s_ss ##1 (!host_req.rd && $stable(sync_status))
            |=> host_rdata == $past(sync_status);
    endproperty
    a_sync_rd: assert property (p_sync_rd) else $error("sync read");
endmodule // e1_ctl_checker

bind e1_control_status_regs e1_ctl_checker u_chk (
    .clk_sys(clk_sys), .rst(rst), .host_req(host_req),
    .host_rdata(host_rdata), .sync_status(sync_status),
    .rx_alarm(rx_alarm), .tx_store_enable(tx_store_enable),
    .chan_block_function_select(chan_block_function_select),
    .tx_backplane_clock_select(tx_backplane_clock_select),
    .es_reset_pulse(es_reset_pulse), .li_reset_pulse(li_reset_pulse),
    .li_recovering(li_recovering), .remote_loop(remote_loop),
    .tx_serial_ignore(tx_serial_ignore), .force_ais(force_ais)
);

// *** verif/host_port_model.sv ***
// Host processor model on the parallel port of the register bank.
// Assumes requests are taken on the rising edge of clk_sys.
`timescale 1ns/1ps
module host_port_model (
    input wire logic clk_sys,
    input wire logic [7:0] host_rdata,
    output e1_ctl_pkg::host_req_s host_req
);
    initial host_req = '0;
    // One write strobe, then the bus shows inverted values
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 host_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        #1 host_req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask
    // One read strobe, data taken a cycle after the taking edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1 host_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        #1 host_req = '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
        @(posedge clk_sys);
        #1 d = host_rdata;
    endtask
    // Mask write, read, masked write back
    task automatic poll(input logic [7:0] a, input logic [7:0] m);
        logic [7:0] d;
        wr_reg(a, m);
        rd_reg(a, d);
        wr_reg(a, d & m);
    endtask
    // Start-up: all registers but sync status, line reset rise, store reset toggle
    task automatic power_up();
        logic [7:0] regs [8];
        regs = '{8'h06, 8'h07, 8'h08, 8'h14, 8'h16, 8'h17, 8'h1a, 8'h1b};
        foreach (regs[i]) wr_reg(regs[i], 8'h00);
        wr_reg(8'h1b, 8'h08);
        wr_reg(8'h1b, 8'h10);
        wr_reg(8'h1b, 8'h00);
    endtask
endmodule // host_port_model

// *** verif/e1_control_status_regs_bench.sv ***
// Self-checking bench for the E1 control and status register bank.
// Assumes the checker and host model files are compiled first.
`timescale 1ns/1ps
module e1_control_status_regs_bench;
    localparam int unsigned LI_CYC = 20;
    logic clk_sys, rst;
    e1_ctl_pkg::host_req_s host_req;
    logic [7:0] host_rdata, s1_evt, s2_evt, sync_st, d, m;
    e1_ctl_pkg::rx_info_evt_s ri_evt;
    e1_ctl_pkg::rx_alarm_s alarm;
    logic tx_se, cbfs, irfs, clk_sel, es_p, li_p, li_rec, ll, rl, fl;
    logic rx_ctx, ts_ign, f_ais, f_ra, irq1, irq2;
    logic [7:0] exp_q [$];
    int error_cnt = 0;
    int checks = 0;
    int n;
    e1_control_status_regs #(.LI_RECOVER_CYCLES(LI_CYC)) dut (
        .clk_sys(clk_sys), .rst(rst), .host_req(host_req),
        .host_rdata(host_rdata), .status_one_evt(s1_evt),
        .status_two_evt(s2_evt), .rx_info_evt(ri_evt),
        .sync_status(sync_st), .rx_alarm(alarm),
        .tx_store_enable(tx_se), .chan_block_function_select(cbfs),
        .idle_reg_function_select(irfs),
        .tx_backplane_clock_select(clk_sel), .es_reset_pulse(es_p),
        .li_reset_pulse(li_p), .li_recovering(li_rec), .local_loop(ll),
        .remote_loop(rl), .framer_loop(fl), .rx_clock_from_tx(rx_ctx),
        .tx_serial_ignore(ts_ign), .force_ais(f_ais),
        .force_remote_alarm(f_ra), .irq_out_one(irq1), .irq_out_two(irq2)
    );
    host_port_model u_host (
        .clk_sys(clk_sys), .host_rdata(host_rdata), .host_req(host_req)
    );
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("errors=%0d checks=%0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tk(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    // Reads and polls note their expected data first
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.rd_reg(a, d);
    endtask
    task automatic pl(input int r, input logic [7:0] mk, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.poll(e1_ctl_pkg::ADDR_STATUS_ONE + 8'(r), mk);
    endtask
    // One-cycle event on status one, two or receive information
    task automatic ev(input int r, input logic [7:0] v);
        if (r == 0) s1_evt = v;
        else if (r == 1) s2_evt = v;
        else ri_evt = v;
        tk(1);
        s1_evt = 8'h00;
        s2_evt = 8'h00;
        ri_evt = '0;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Read data is compared two edges after the taking edge
    initial begin
        forever begin
            @(posedge clk_sys);
            if (host_req.rd === 1'b1) begin
                repeat (2) @(posedge clk_sys);
                #2 chk(host_rdata, exp_q.pop_front());
            end
        end
    end
    initial begin
        #100000 error_cnt++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        s1_evt = 8'h00;
        s2_evt = 8'h00;
        ri_evt = '0;
        alarm = '0;
        sync_st = 8'h00;
        n = $urandom(87787);
        tk(5);
        rst = 1'b0;
        u_host.power_up();
        // Control three fields reach their outputs and read back
        repeat (8) begin
            d = 8'($urandom) & 8'he2;
            m = d;
            u_host.wr_reg(e1_ctl_pkg::ADDR_CTL_THREE, m);
            chk({tx_se, cbfs, irfs, clk_sel}, {m[7:5], m[1]});
            rd(e1_ctl_pkg::ADDR_CTL_THREE, m & 8'hfa);
        end
        // Store reset fires once, on the falling bit
        u_host.wr_reg(e1_ctl_pkg::ADDR_CTL_THREE, 8'h10);
        chk(es_p, 8'h00);
        u_host.wr_reg(e1_ctl_pkg::ADDR_CTL_THREE, 8'h00);
        tk(1);
        chk(es_p, 8'h01);
        tk(1);
        chk(es_p, 8'h00);
        // Line reset pulse and the recovery span
        u_host.wr_reg(e1_ctl_pkg::ADDR_CTL_THREE, 8'h08);
        tk(1);
        chk(li_p, 8'h01);
        // Recovery shows one cycle after the pulse
        tk(1);
        n = 0;
        while (li_rec === 1'b1 && n < 100) begin
            n++;
            tk(1);
        end
        chk(8'(n), 8'(LI_CYC));
        u_host.wr_reg(e1_ctl_pkg::ADDR_CTL_THREE, 8'h00);
        // All loopback combinations
        for (int i = 0; i < 8; i++) begin
            u_host.wr_reg(e1_ctl_pkg::ADDR_CTL_TWO, 8'(i) & 8'h03);
            u_host.wr_reg(e1_ctl_pkg::ADDR_CTL_ONE, 8'(i << 5));
            m = 8'({i[0], i[1], i[1], i[2], i[2]});
            chk({ll, rl, ts_ign, fl, rx_ctx}, m);
        end
        // Alarm causes with no, remote and AIS enable, one at a time
        for (int k = 3; k < 6; k++) begin
            u_host.wr_reg(e1_ctl_pkg::ADDR_CTL_TWO, 8'h01 << k);
            for (int a = 0; a < 8; a++) begin
                alarm = 3'(a);
                tk(2);
                chk({f_ais, f_ra}, {k == 5 && a != 0, k == 4 && a != 0});
            end
        end
        alarm = '0;
        // Every latched bit sets and clears by poll; only status one and two interrupt
        u_host.wr_reg(e1_ctl_pkg::ADDR_IRQ_MASK_ONE, 8'hff);
        u_host.wr_reg(e1_ctl_pkg::ADDR_IRQ_MASK_TWO, 8'hff);
        for (int r = 0; r < 3; r++) begin
            for (int b = 0; b < 8; b++) begin
                ev(r, 8'h01 << b);
                tk(1);
                chk({irq1, irq2}, {r == 0, r == 1});
                pl(r, 8'h01 << b, 8'h01 << b);
                chk({irq1, irq2}, 8'h00);
            end
        end
        // Zero mask bits keep the older read value; masked irq stays low
        u_host.wr_reg(e1_ctl_pkg::ADDR_IRQ_MASK_ONE, 8'h00);
        m = 8'h01 << ($urandom % 8);
        ev(0, m | {m[6:0], m[7]});
        tk(1);
        chk(irq1, 8'h00);
        pl(0, m, m);
        pl(0, {m[6:0], m[7]}, {m[6:0], m[7]});
        pl(0, 8'hff, 8'h00);
        // Live sync status, write ignored, unmapped read
        sync_st = 8'($urandom);
        rd(e1_ctl_pkg::ADDR_SYNC_STATUS, sync_st);
        u_host.wr_reg(e1_ctl_pkg::ADDR_SYNC_STATUS, ~sync_st);
        rd(e1_ctl_pkg::ADDR_SYNC_STATUS, sync_st);
        rd(8'h3f, e1_ctl_pkg::READ_UNMAPPED);
        // Let the watcher compare the last read
        tk(2);
        end_of_test();
    end
endmodule // e1_control_status_regs_bench
